// ==== core/eelc_defines.svh ====
// register map, field layout, reset values and sizes of the edge event line controller
//
// Notes on behaviour
// R01 - twenty-three independent edge lines, each raising an interrupt and an event request
// R02 - per line trigger choice: rising only, falling only, or both edges
// R03 - per line mask; a masked line forwards nothing and leaves others alone
// R04 - pending bit per line set by the selected edge, readable by software
// R05 - pulses shorter than one bus clock period are still caught
// R06 - sixteen lines fed from general pins, any of up to 83 pins selectable
// R07 - seven lines fed by clock alarm, supply monitor, usb and comparator events
// R08 - pending bit stays set until software writes one to it; zero leaves it
`ifndef EELC_DEFINES_SVH
`define EELC_DEFINES_SVH

// ----------------------------------------------------------------
// sizes
// ----------------------------------------------------------------
`define EELC_NUM_LINES      23
`define EELC_NUM_PIN_LINES  16
`define EELC_NUM_INT_LINES  7
`define EELC_NUM_PINS       83
`define EELC_SEL_W          7
`define EELC_ADDR_W         6

// ----------------------------------------------------------------
// byte offsets on the register bus
// ----------------------------------------------------------------
`define EELC_OFS_RISE       6'h00
`define EELC_OFS_FALL       6'h04
`define EELC_OFS_INTR_EN    6'h08
`define EELC_OFS_EVENT_EN   6'h0C
`define EELC_OFS_PENDING    6'h10
`define EELC_OFS_SEL0       6'h20
`define EELC_OFS_SEL1       6'h24
`define EELC_OFS_SEL2       6'h28
`define EELC_OFS_SEL3       6'h2C

// ----------------------------------------------------------------
// field layout and reset values
// ----------------------------------------------------------------
`define EELC_SEL_FIELD_STRIDE  8
`define EELC_SEL_PER_WORD      4
`define EELC_SEL_MASK          32'h7F7F7F7F
`define EELC_RST_LINES         23'h000000
`define EELC_RST_SEL0          32'h03020100
`define EELC_RST_SEL1          32'h07060504
`define EELC_RST_SEL2          32'h0B0A0908
`define EELC_RST_SEL3          32'h0F0E0D0C

`endif

// ==== core/eelc_pkg.sv ====
// types shared by the edge event line controller files
package eelc_pkg;

    // one bit per edge line
    typedef logic [22:0] line_vec_t;

    // avalon request from the bus master
    typedef struct packed {
        logic        read;
        logic        write;
        logic [5:0]  address;
        logic [31:0] writedata;
        logic [3:0]  byteenable;
    } bus_req_t;

    // bus slave sequencing
    typedef enum logic {
        BUS_IDLE,
        BUS_ANSWER
    } bus_state_t;

endpackage

// ==== core/edge_capture.sv ====
// asynchronous edge catcher with toggle crossing into the bus clock domain
`timescale 1ns/10ps
`default_nettype none
module edge_capture (
    // clock and reset
    input  wire logic i_clock,
    input  wire logic i_rst,
    // raw line, any timing
    input  wire logic i_line,
    // one-cycle pulses on i_clock
    output logic      o_rise,
    output logic      o_fall
);
    logic rise_tog_reg;
    logic fall_tog_reg;
    logic [1:0] rise_sync_reg;
    logic [1:0] fall_sync_reg;
    logic rise_seen_reg;
    logic fall_seen_reg;

    // ------------------------------------------------------------
    // capture on the line itself
    // ------------------------------------------------------------
    // toggles need no clear from the clock side, so a narrow pulse is never raced
    always_ff @(posedge i_line or posedge i_rst) begin
        if (i_rst) begin
            rise_tog_reg <= 1'b0;
        end else begin
            rise_tog_reg <= ~rise_tog_reg; // R05
        end
    end

    // falling edge toggles a second flop
    always_ff @(negedge i_line or posedge i_rst) begin
        if (i_rst) begin
            fall_tog_reg <= 1'b0;
        end else begin
            fall_tog_reg <= ~fall_tog_reg; // R05
        end
    end

    // ------------------------------------------------------------
    // crossing and change detect
    // ------------------------------------------------------------
    // two edges of one kind between two samples on i_clock cancel; a limitation
    always_ff @(posedge i_clock or posedge i_rst) begin
        if (i_rst) begin
            rise_sync_reg <= 2'h0;
            fall_sync_reg <= 2'h0;
            rise_seen_reg <= 1'b0;
            fall_seen_reg <= 1'b0;
            o_rise        <= 1'b0;
            o_fall        <= 1'b0;
        end else begin
            rise_sync_reg <= {rise_sync_reg[0], rise_tog_reg};
            fall_sync_reg <= {fall_sync_reg[0], fall_tog_reg};
            rise_seen_reg <= rise_sync_reg[1];
            fall_seen_reg <= fall_sync_reg[1];
            o_rise        <= rise_sync_reg[1] ^ rise_seen_reg; // R05
            o_fall        <= fall_sync_reg[1] ^ fall_seen_reg;
        end
    end

    // ------------------------------------------------------------
    // checks
    // ------------------------------------------------------------
    a_rise_one_pulse: assert property (@(posedge i_clock) disable iff (i_rst) // R05
        o_rise |=> !o_rise) else $error("rise pulse longer than one cycle");
endmodule
`default_nettype wire

// ==== core/edge_event_line_controller.sv ====
// edge event line controller: line capture, trigger select, pending, masks, avalon slave
`timescale 1ns/10ps
`default_nettype none
`include "eelc_defines.svh"
module edge_event_line_controller #(
    parameter int NUM_PINS = `EELC_NUM_PINS
) (
    // clock and reset
    input  wire logic                  i_clock,
    input  wire logic                  i_rst,
    // avalon slave
    input  wire eelc_pkg::bus_req_t    i_bus,
    output logic [31:0]                o_bus_readdata,
    output logic                       o_bus_waitrequest,
    // line sources
    input  wire logic [NUM_PINS-1:0]   i_pin,
    input  wire logic [6:0]            i_internal_event,
    // requests
    output eelc_pkg::line_vec_t        o_event,
    output logic                       o_irq
);
    // ------------------------------------------------------------
    // elaboration checks
    // ------------------------------------------------------------
    if (NUM_PINS < 1 || NUM_PINS > (1 << `EELC_SEL_W)) begin : g_bad_pins
        $error("NUM_PINS must be 1 to 128");
    end

    // ------------------------------------------------------------
    // declarations
    // ------------------------------------------------------------
    eelc_pkg::line_vec_t   rise_enable_reg;
    eelc_pkg::line_vec_t   fall_enable_reg;
    eelc_pkg::line_vec_t   intr_enable_reg;
    eelc_pkg::line_vec_t   event_enable_reg;
    eelc_pkg::line_vec_t   pending_reg;
    eelc_pkg::line_vec_t   pending_next;
    eelc_pkg::line_vec_t   line_in;
    eelc_pkg::line_vec_t   rise_vec;
    eelc_pkg::line_vec_t   fall_vec;
    eelc_pkg::line_vec_t   set_vec;
    eelc_pkg::line_vec_t   clear_vec;
    logic [3:0][31:0]      sel_word_reg;
    eelc_pkg::bus_state_t  bus_state_reg;
    logic                  wr_en;
    logic [31:0]           rd_word;

    // ------------------------------------------------------------
    // functions
    // ------------------------------------------------------------
    // byte-lane merge of a write into a stored word
    function automatic logic [31:0] wmerge(input logic [31:0] old,
                                           input logic [31:0] d,
                                           input logic [3:0]  be);
        logic [31:0] r;
        r = old;
        for (int b = 0; b < 4; b++) begin
            if (be[b]) begin
                r[8*b +: 8] = d[8*b +: 8];
            end
        end
        return r;
    endfunction

    // byte-lane merge for a line-wide register; upper bits are dropped
    function automatic eelc_pkg::line_vec_t wline(input eelc_pkg::line_vec_t old,
                                                  input logic [31:0]         d,
                                                  input logic [3:0]          be);
        logic [31:0] m;
        m = wmerge({9'h000, old}, d, be);
        return m[22:0];
    endfunction

    // pin pick; an index past the last pin reads as low
    function automatic logic pick_pin(input logic [NUM_PINS-1:0]     pins,
                                      input logic [`EELC_SEL_W-1:0] sel);
        logic r;
        r = 1'b0;
        for (int p = 0; p < NUM_PINS; p++) begin
            if (sel == p[`EELC_SEL_W-1:0]) begin
                r = pins[p];
            end
        end
        return r;
    endfunction

    // ------------------------------------------------------------
    // line sources
    // ------------------------------------------------------------
    // pins go to the catchers unsampled so narrow pulses survive;
    // changing a selector can itself look like an edge on that line
    always_comb begin
        line_in = '0;
        for (int i = 0; i < `EELC_NUM_PIN_LINES; i++) begin
            line_in[i] = pick_pin(i_pin, sel_word_reg[i / `EELC_SEL_PER_WORD]
                [`EELC_SEL_FIELD_STRIDE * (i % `EELC_SEL_PER_WORD) +: `EELC_SEL_W]); // R06
        end
        line_in[22:16] = i_internal_event; // R07
    end

    // ------------------------------------------------------------
    // edge catchers, one per line
    // ------------------------------------------------------------
    for (genvar g = 0; g < `EELC_NUM_LINES; g++) begin : g_line // R01
        edge_capture u_capture (
            .i_clock (i_clock),
            .i_rst   (i_rst),
            .i_line  (line_in[g]),
            .o_rise  (rise_vec[g]),
            .o_fall  (fall_vec[g])
        );
    end

    // ------------------------------------------------------------
    // trigger select and pending
    // ------------------------------------------------------------
    // both enables set gives both-edge triggering
    assign set_vec = (rise_vec & rise_enable_reg) | (fall_vec & fall_enable_reg); // R02

    // write-one-to-clear, restricted to enabled byte lanes
    always_comb begin
        clear_vec = '0;
        if (wr_en && i_bus.address == `EELC_OFS_PENDING) begin
            clear_vec = wline('0, i_bus.writedata, i_bus.byteenable); // R08
        end
    end

    // an edge in the clearing cycle wins, so it is never lost
    assign pending_next = (pending_reg & ~clear_vec) | set_vec; // R04 R08

    // pending is recorded whatever the masks, as status for software
    always_ff @(posedge i_clock or posedge i_rst) begin
        if (i_rst) begin
            pending_reg <= `EELC_RST_LINES;
        end else begin
            pending_reg <= pending_next; // R04
        end
    end

    // ------------------------------------------------------------
    // request outputs
    // ------------------------------------------------------------
    // event is a pulse per edge, interrupt a level from pending
    always_ff @(posedge i_clock or posedge i_rst) begin
        if (i_rst) begin
            o_event <= `EELC_RST_LINES;
            o_irq   <= 1'b0;
        end else begin
            o_event <= set_vec & event_enable_reg;        // R01 R03
            o_irq   <= |(pending_reg & intr_enable_reg);  // R01 R03
        end
    end

    // ------------------------------------------------------------
    // configuration registers
    // ------------------------------------------------------------
    // writes land on the edge at which waitrequest is seen low
    assign wr_en = (bus_state_reg == eelc_pkg::BUS_ANSWER) && i_bus.write;

    // trigger and mask registers
    always_ff @(posedge i_clock or posedge i_rst) begin
        if (i_rst) begin
            rise_enable_reg  <= `EELC_RST_LINES;
            fall_enable_reg  <= `EELC_RST_LINES;
            intr_enable_reg  <= `EELC_RST_LINES;
            event_enable_reg <= `EELC_RST_LINES;
        end else if (wr_en) begin
            case (i_bus.address)
                `EELC_OFS_RISE: begin
                    rise_enable_reg <= wline(rise_enable_reg, i_bus.writedata,
                                             i_bus.byteenable); // R02
                end
                `EELC_OFS_FALL: begin
                    fall_enable_reg <= wline(fall_enable_reg, i_bus.writedata,
                                             i_bus.byteenable); // R02
                end
                `EELC_OFS_INTR_EN: begin
                    intr_enable_reg <= wline(intr_enable_reg, i_bus.writedata,
                                             i_bus.byteenable); // R03
                end
                `EELC_OFS_EVENT_EN: begin
                    event_enable_reg <= wline(event_enable_reg, i_bus.writedata,
                                              i_bus.byteenable); // R03
                end
                default: begin
                end
            endcase
        end
    end

    // pin selectors, four seven-bit fields per word
    always_ff @(posedge i_clock or posedge i_rst) begin
        if (i_rst) begin
            sel_word_reg[0] <= `EELC_RST_SEL0;
            sel_word_reg[1] <= `EELC_RST_SEL1;
            sel_word_reg[2] <= `EELC_RST_SEL2;
            sel_word_reg[3] <= `EELC_RST_SEL3;
        end else if (wr_en) begin
            for (int w = 0; w < 4; w++) begin
                if (i_bus.address == `EELC_OFS_SEL0 + 6'(4 * w)) begin
                    sel_word_reg[w] <= wmerge(sel_word_reg[w], i_bus.writedata,
                                              i_bus.byteenable) & `EELC_SEL_MASK; // R06
                end
            end
        end
    end

    // ------------------------------------------------------------
    // read decode
    // ------------------------------------------------------------
    // unmapped offsets read as zero
    always_comb begin
        case (i_bus.address)
            `EELC_OFS_RISE:     rd_word = {9'h000, rise_enable_reg};
            `EELC_OFS_FALL:     rd_word = {9'h000, fall_enable_reg};
            `EELC_OFS_INTR_EN:  rd_word = {9'h000, intr_enable_reg};
            `EELC_OFS_EVENT_EN: rd_word = {9'h000, event_enable_reg};
            `EELC_OFS_PENDING:  rd_word = {9'h000, pending_reg};
            `EELC_OFS_SEL0:     rd_word = sel_word_reg[0];
            `EELC_OFS_SEL1:     rd_word = sel_word_reg[1];
            `EELC_OFS_SEL2:     rd_word = sel_word_reg[2];
            `EELC_OFS_SEL3:     rd_word = sel_word_reg[3];
            default:            rd_word = 32'h00000000;
        endcase
    end

    // ------------------------------------------------------------
    // avalon slave sequencing
    // ------------------------------------------------------------
    // fixed one wait state keeps readdata and waitrequest registered
    always_ff @(posedge i_clock or posedge i_rst) begin
        if (i_rst) begin
            bus_state_reg     <= eelc_pkg::BUS_IDLE;
            o_bus_waitrequest <= 1'b1;
            o_bus_readdata    <= 32'h00000000;
        end else begin
            case (bus_state_reg)
                eelc_pkg::BUS_IDLE: begin
                    if (i_bus.read || i_bus.write) begin
                        bus_state_reg     <= eelc_pkg::BUS_ANSWER;
                        o_bus_waitrequest <= 1'b0;
                        o_bus_readdata    <= i_bus.read ? rd_word : 32'h00000000;
                    end
                end
                eelc_pkg::BUS_ANSWER: begin
                    bus_state_reg     <= eelc_pkg::BUS_IDLE;
                    o_bus_waitrequest <= 1'b1;
                end
                default: begin
                    bus_state_reg     <= eelc_pkg::BUS_IDLE;
                    o_bus_waitrequest <= 1'b1;
                end
            endcase
        end
    end

    // ------------------------------------------------------------
    // checks
    // ------------------------------------------------------------
    default clocking cb @(posedge i_clock);
    endclocking
    default disable iff (i_rst);

    a_irq_follows_pending: assert property ( // R03
        (|(pending_reg & intr_enable_reg)) |=> o_irq)
        else $error("unmasked pending without interrupt");

    a_irq_masked_quiet: assert property ( // R03
        !(|(pending_reg & intr_enable_reg)) |=> !o_irq)
        else $error("interrupt with nothing unmasked pending");

    a_pending_set_edge: assert property ( // R04
        (|set_vec) |=> ((pending_reg & $past(set_vec)) == $past(set_vec)))
        else $error("selected edge did not set pending");

    a_pending_sticky: assert property ( // R08
        (($past(pending_reg) & ~pending_reg & ~$past(clear_vec)) == 23'h000000))
        else $error("pending dropped without a write of one");

    a_event_masked: assert property ( // R03
        ((o_event & ~$past(event_enable_reg)) == 23'h000000))
        else $error("masked line forwarded an event");

    a_event_has_edge: assert property ( // R02
        (|o_event) |-> $past(|(rise_vec | fall_vec)))
        else $error("event without a line edge");

    a_bus_answers: assert property ( // R04
        (bus_state_reg == eelc_pkg::BUS_IDLE && (i_bus.read || i_bus.write))
        |=> !o_bus_waitrequest ##1 o_bus_waitrequest)
        else $error("bus answer not exactly one cycle after request");

    a_pending_read: assert property ( // R04
        (bus_state_reg == eelc_pkg::BUS_IDLE && i_bus.read
         && i_bus.address == `EELC_OFS_PENDING)
        |=> (o_bus_readdata == {9'h000, $past(pending_reg)}))
        else $error("pending read returned wrong data");

    c_rise_pending: cover property ((|(rise_vec & rise_enable_reg)) ##1 (|pending_reg));
    c_set_and_clear: cover property (|(set_vec & clear_vec));
    c_irq_raised: cover property ($rose(o_irq));
    c_both_edges: cover property (|(rise_vec & fall_vec & rise_enable_reg & fall_enable_reg));
endmodule
`default_nettype wire

// ==== dv/line_source_model.sv ====
// far-side model: general pins and internal event sources feeding the line controller
`timescale 1ns/10ps
`default_nettype none
module line_source_model #(
    parameter int NUM_PINS = 83
) (
    // pin and internal event levels
    output var logic [NUM_PINS-1:0] o_pin,
    output var logic [6:0]          o_internal_event
);
    // ----------------------------------------------------------------
    // level control, called by the bench right after a clock edge; the narrow pulse starts 10 ns after one
    // ----------------------------------------------------------------
    // all sources start low so the first edge is the bench's own
    initial begin
        o_pin            = '0;
        o_internal_event = '0;
    end

    // general pin level, any pin up to the top one
    task automatic set_pin(input int idx, input logic v);
        o_pin[idx] <= v;
    endtask

    // clock alarm, supply monitor, usb and comparator sources
    task automatic set_int(input int idx, input logic v);
        o_internal_event[idx] <= v;
    endtask

    // pulse far narrower than one bus clock period, placed off the edge
    task automatic pulse_pin(input int idx);
        o_pin[idx] = 1'b1;
        #5;
        o_pin[idx] = 1'b0;
    endtask
endmodule
`default_nettype wire

// ==== dv/tb.sv ====
// self-checking bench for the edge event line controller
`timescale 1ns/10ps
`default_nettype none
`include "eelc_defines.svh"
module tb;
    // ----------------------------------------------------------------
    // clock, reset and hookup
    // ----------------------------------------------------------------
    localparam int NP = 83;
    typedef struct {int line; logic rise; logic fall; logic up; logic exp;} row_t;
    logic                i_clock      = 1'b0;
    logic                i_rst;
    eelc_pkg::bus_req_t  bus          = '0;
    logic [31:0]         rdata;
    logic                wait_req;
    logic [NP-1:0]       pin;
    logic [6:0]          int_ev;
    eelc_pkg::line_vec_t ev;
    logic                irq;
    eelc_pkg::line_vec_t ev_seen      = '0;
    logic                ev_clr       = 1'b0;
    int                  ev_cnt       = 0;
    int                  n_errors     = 0;
    int                  total_checks = 0;
    logic [31:0]         q;
    logic [5:0]          reg_ofs [10] = '{`EELC_OFS_RISE, `EELC_OFS_FALL, `EELC_OFS_INTR_EN,
        `EELC_OFS_EVENT_EN, `EELC_OFS_PENDING, `EELC_OFS_SEL0, `EELC_OFS_SEL1,
        `EELC_OFS_SEL2, `EELC_OFS_SEL3, 6'h30};
    logic [31:0]         reg_rst [10] = '{32'h0, 32'h0, 32'h0, 32'h0, 32'h0, `EELC_RST_SEL0,
        `EELC_RST_SEL1, `EELC_RST_SEL2, `EELC_RST_SEL3, 32'h0};
    // line, rise enable, fall enable, edge direction (1 = up), pending expected
    row_t                rows [10]    = '{'{0, 1, 0, 1, 1}, '{3, 1, 0, 0, 0}, '{5, 0, 1, 0, 1},
        '{7, 0, 1, 1, 0}, '{15, 1, 1, 1, 1}, '{15, 1, 1, 0, 1}, '{16, 1, 0, 1, 1},
        '{19, 0, 1, 0, 1}, '{22, 1, 1, 0, 1}, '{9, 0, 0, 1, 0}};

    always #20 i_clock = ~i_clock;

    edge_event_line_controller #(.NUM_PINS(NP)) u_dut (.i_clock(i_clock), .i_rst(i_rst),
        .i_bus(bus), .o_bus_readdata(rdata), .o_bus_waitrequest(wait_req), .i_pin(pin),
        .i_internal_event(int_ev), .o_event(ev), .o_irq(irq));
    line_source_model #(.NUM_PINS(NP)) u_src (.o_pin(pin), .o_internal_event(int_ev));

    // gather one-cycle event pulses so none slips between bus reads
    always @(posedge i_clock) begin
        if (ev_clr) begin
            ev_seen <= '0;
            ev_cnt  <= 0;
        end else begin
            ev_seen <= ev_seen | ev;
            ev_cnt  <= ev_cnt + ((ev != '0) ? 1 : 0);
        end
    end

    // ----------------------------------------------------------------
    // compare, bus and source tasks
    // ----------------------------------------------------------------
    task automatic chk_word(input string name, input logic [31:0] exp, input logic [31:0] got);
        total_checks++;
        if (got !== exp) begin
            n_errors++;
            $display("BAD %s expected %h seen %h", name, exp, got);
        end
    endtask

    task automatic chk_bit(input string name, input logic exp, input logic got);
        total_checks++;
        if (got !== exp) begin
            n_errors++;
            $display("BAD %s expected %b seen %b", name, exp, got);
        end
    endtask

    // one avalon transfer; an extra edge after release keeps requests apart
    task automatic xfer(input logic wr, input logic [5:0] a, input logic [31:0] d);
        int n;
        n = 0;
        bus.read       <= ~wr;
        bus.write      <= wr;
        bus.address    <= a;
        bus.writedata  <= d;
        bus.byteenable <= 4'hF;
        @(posedge i_clock);
        while (wait_req !== 1'b0 && n < 20) begin
            @(posedge i_clock);
            n++;
        end
        chk_bit("waitrequest answer", 1'b0, wait_req);
        q = rdata;
        bus.read  <= 1'b0;
        bus.write <= 1'b0;
        @(posedge i_clock);
    endtask

    task automatic rd_chk(input string name, input logic [5:0] a, input logic [31:0] exp);
        xfer(1'b0, a, 32'h0);
        chk_word(name, exp, q);
    endtask

    // lines below sixteen sit on their reset pins, the rest on internal sources
    task automatic src(input int line, input logic v);
        if (line < 16) u_src.set_pin(line, v);
        else u_src.set_int(line - 16, v);
    endtask

    // let stray edges land, then clear pending bits and gathered events
    task automatic settle_clear();
        repeat (8) @(posedge i_clock);
        xfer(1'b1, `EELC_OFS_PENDING, 32'h007FFFFF);
        ev_clr <= 1'b1;
        @(posedge i_clock);
        ev_clr <= 1'b0;
    endtask

    task automatic stop_test();
        $display("checks %0d mismatches %0d", total_checks, n_errors);
        if (n_errors == 0 && total_checks > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask

    // watchdog: the whole run needs a few hundred cycles
    initial begin
        repeat (20000) @(posedge i_clock);
        n_errors++;
        $display("BAD watchdog expected finish seen timeout");
        stop_test();
    end

    // ----------------------------------------------------------------
    // main sequence
    // ----------------------------------------------------------------
    initial begin
        // a real rising edge, so the line-clocked catchers reset as well
        i_rst <= 1'b1;
        repeat (6) @(posedge i_clock);
        chk_bit("irq in reset", 1'b0, irq);
        chk_word("event in reset", 32'h0, {9'h0, ev});
        chk_bit("waitrequest in reset", 1'b1, wait_req);
        i_rst <= 1'b0;
        @(posedge i_clock);
        foreach (reg_ofs[i]) rd_chk("reset value", reg_ofs[i], reg_rst[i]);
        xfer(1'b1, `EELC_OFS_RISE, 32'hFFFFFFFF);
        rd_chk("upper bits", `EELC_OFS_RISE, 32'h007FFFFF);
        xfer(1'b1, 6'h30, 32'hFFFFFFFF);
        rd_chk("unmapped", 6'h30, 32'h0);
        $display("test registers done");
        // ordinary cases from the table
        xfer(1'b1, `EELC_OFS_EVENT_EN, 32'h007FFFFF);
        foreach (rows[i]) begin
            xfer(1'b1, `EELC_OFS_RISE, rows[i].rise ? (32'h1 << rows[i].line) : 32'h0);
            xfer(1'b1, `EELC_OFS_FALL, rows[i].fall ? (32'h1 << rows[i].line) : 32'h0);
            src(rows[i].line, ~rows[i].up);
            settle_clear();
            src(rows[i].line, rows[i].up);
            repeat (8) @(posedge i_clock);
            q = rows[i].exp ? (32'h1 << rows[i].line) : 32'h0;
            chk_word("event lines", q, {9'h0, ev_seen});
            chk_word("event pulses", {31'h0, rows[i].exp}, ev_cnt);
            rd_chk("pending", `EELC_OFS_PENDING, q);
        end
        $display("test edge table done");
        // pin selector: line 4 moved to the top pin, its old pin no longer counts
        xfer(1'b1, `EELC_OFS_SEL1, 32'h878685D2);
        rd_chk("selector", `EELC_OFS_SEL1, 32'h07060552);
        xfer(1'b1, `EELC_OFS_RISE, 32'h10);
        settle_clear();
        u_src.set_pin(4, 1'b1);
        repeat (8) @(posedge i_clock);
        rd_chk("old pin", `EELC_OFS_PENDING, 32'h0);
        u_src.set_pin(82, 1'b1);
        repeat (8) @(posedge i_clock);
        rd_chk("new pin", `EELC_OFS_PENDING, 32'h10);
        xfer(1'b1, `EELC_OFS_SEL1, `EELC_RST_SEL1);
        u_src.set_pin(4, 1'b0);
        $display("test selector done");
        // masks and interrupt: line 2 interrupt only, line 4 event only
        xfer(1'b1, `EELC_OFS_RISE, 32'h14);
        xfer(1'b1, `EELC_OFS_INTR_EN, 32'h4);
        xfer(1'b1, `EELC_OFS_EVENT_EN, 32'h10);
        u_src.set_pin(2, 1'b0);
        settle_clear();
        u_src.set_pin(2, 1'b1);
        u_src.set_pin(4, 1'b1);
        repeat (8) @(posedge i_clock);
        chk_word("masked events", 32'h10, {9'h0, ev_seen});
        chk_bit("irq unmasked", 1'b1, irq);
        rd_chk("pending both", `EELC_OFS_PENDING, 32'h14);
        xfer(1'b1, `EELC_OFS_INTR_EN, 32'h0);
        @(posedge i_clock);
        chk_bit("irq masked", 1'b0, irq);
        xfer(1'b1, `EELC_OFS_PENDING, 32'h0);
        rd_chk("zero write", `EELC_OFS_PENDING, 32'h14);
        xfer(1'b1, `EELC_OFS_INTR_EN, 32'h4);
        xfer(1'b1, `EELC_OFS_PENDING, 32'h4);
        @(posedge i_clock);
        chk_bit("irq after clear", 1'b0, irq);
        rd_chk("one cleared", `EELC_OFS_PENDING, 32'h10);
        xfer(1'b1, `EELC_OFS_INTR_EN, 32'h10);
        @(posedge i_clock);
        chk_bit("irq other line", 1'b1, irq);
        xfer(1'b1, `EELC_OFS_PENDING, 32'h10);
        @(posedge i_clock);
        chk_bit("irq all clear", 1'b0, irq);
        $display("test masks done");
        // pulse narrower than one clock period, rising then falling trigger
        for (int k = 0; k < 2; k++) begin
            xfer(1'b1, `EELC_OFS_RISE, (k == 0) ? 32'h2 : 32'h0);
            xfer(1'b1, `EELC_OFS_FALL, (k == 0) ? 32'h0 : 32'h2);
            settle_clear();
            #10;
            u_src.pulse_pin(1);
            repeat (8) @(posedge i_clock);
            rd_chk("narrow pulse", `EELC_OFS_PENDING, 32'h2);
        end
        $display("test narrow pulse done");
        // reset in mid-run drops pending state and the interrupt
        xfer(1'b1, `EELC_OFS_INTR_EN, 32'h2);
        @(posedge i_clock);
        chk_bit("irq before reset", 1'b1, irq);
        i_rst <= 1'b1;
        repeat (2) @(posedge i_clock);
        chk_bit("irq in reset", 1'b0, irq);
        chk_bit("waitrequest in reset", 1'b1, wait_req);
        i_rst <= 1'b0;
        @(posedge i_clock);
        rd_chk("pending after reset", `EELC_OFS_PENDING, 32'h0);
        rd_chk("mask after reset", `EELC_OFS_INTR_EN, 32'h0);
        $display("test mid-run reset done");
        stop_test();
    end
endmodule
`default_nettype wire
